// file: rtl/spa_pkg.sv
package spa_pkg;

  // ----------------------------------------------------------------
  // Frame timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 40;
  localparam int SAMPLE_NS   = 10240;
  localparam int PERIOD_CYC  = SAMPLE_NS / CLK_NS;
  localparam int HALF_CYC    = PERIOD_CYC / 2;
  // Keeps the secondary exchange inside a shortened frame
  localparam int MIN_GAP_CYC = 20;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_W      = 16;
  localparam int DAC_LSB     = 2;
  localparam int DAC_W       = WORD_W - DAC_LSB;
  localparam int REQ_ONE_POS = 1;
  localparam int REQ_ZER_POS = 0;
  localparam int SEC_TOP_POS = 15;
  localparam int SEC_NXT_POS = 14;
  localparam int STEP_W      = 8;
  localparam int FIFO_DEPTH  = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PRI  = 3'b010,
    ST_SEC  = 3'b100
  } spa_state_e;

  typedef enum logic [1:0] {
    ACT_NONE  = 2'h0,
    ACT_DELAY = 2'h1,
    ACT_ADV   = 2'h2
  } spa_act_e;

  typedef struct packed {
    logic secondary_word_top_bit;
    logic secondary_word_next_bit;
    logic phase_pin_high;
    logic phase_pin_low;
  } spa_sel_s;

  typedef struct packed {
    logic [DAC_W-1:0] data;
    logic             valid;
  } spa_dac_s;

endpackage

// file: rtl/spa_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module spa_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          rdy_ff, nxt_rdy;
  logic          push, pop;

  // ----------------------------------------------------------------
  // Pointers and fill level
  // ----------------------------------------------------------------
  always_comb begin
    push    = in_valid && rdy_ff;
    pop     = out_ready && (cnt_ff != '0);
    nxt_wr  = push ? AW'(wr_ff + 1'b1) : wr_ff;
    nxt_rd  = pop ? AW'(rd_ff + 1'b1) : rd_ff;
    nxt_cnt = (AW+1)'(cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    nxt_rdy = (nxt_cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
      rdy_ff <= 1'b0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
      rdy_ff <= nxt_rdy;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  assign in_ready  = rdy_ff;
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];

endmodule

`default_nettype wire

// file: rtl/spa_phase_ctrl.sv
// Functional notes
// RL1 - Combinations outside the decode table cause no action at all.
// RL2 - Each primary frame takes DAC bits 15..2 in and sends one ADC word out.
// RL3 - Unless both secondary bits are one, the phase pins are ignored.
// RL4 - Secondary bits 01: next sampling instant later by the phase step.
// RL5 - Secondary bits 10: next sampling instant earlier by the phase step; the code stops shortening the frame at MIN_LEN cycles.
// RL6 - Bits 11 with pins low/high: sampling instant later by the phase step.
// RL7 - Bits 11 with pins high/low: sampling instant earlier by the phase step; the code stops shortening the frame at MIN_LEN cycles.
// RL8 - Negative step in a delay decode moves the frame earlier.
// RL9 - Negative step in an advance decode moves the frame later.
// RL10 - Secondary frame sync comes half a period after the primary falling edge.
// RL11 - Bits 11 with equal pins: data exchange only, phase unchanged.
`timescale 1ns/100ps
`default_nettype none

module spa_phase_ctrl #(
  parameter int PERIOD = spa_pkg::PERIOD_CYC,
  parameter int STEPW  = spa_pkg::STEP_W
) (
  input  wire logic                                ref_clk,
  input  wire logic                                sys_rst,
  input  wire logic                                din,
  input  wire logic                                phase_pin_high,
  input  wire logic                                phase_pin_low,
  input  wire logic signed [STEPW-1:0]             phase_step,
  input  wire logic [spa_pkg::WORD_W-1:0]          adc_data,
  input  wire logic                                adc_valid,
  output logic                                     adc_ready,
  output logic                                     frame_sync_n,
  output logic                                     dout,
  output spa_pkg::spa_dac_s                        dac_out,
  output logic [spa_pkg::WORD_W-1:0]               sec_word,
  output logic                                     sec_valid,
  output spa_pkg::spa_act_e                        phase_action
);

  localparam int HALF    = PERIOD / 2;
  localparam int MIN_LEN = HALF + spa_pkg::MIN_GAP_CYC;
  localparam int WW      = spa_pkg::WORD_W;

  // ----------------------------------------------------------------
  // Decode and length arithmetic
  // ----------------------------------------------------------------
  function automatic spa_pkg::spa_act_e decode(input spa_pkg::spa_sel_s s);
    unique case ({s.secondary_word_top_bit, s.secondary_word_next_bit})
      2'b01: decode = spa_pkg::ACT_DELAY;
      2'b10: decode = spa_pkg::ACT_ADV;
      2'b11: begin
        if (s.phase_pin_high == s.phase_pin_low) begin
          decode = spa_pkg::ACT_NONE;
        end else if (s.phase_pin_low) begin
          decode = spa_pkg::ACT_DELAY;
        end else begin
          decode = spa_pkg::ACT_ADV;
        end
      end
      default: decode = spa_pkg::ACT_NONE;
    endcase
  endfunction

  // Clamped so a large step cannot swallow the secondary exchange
  function automatic logic [15:0] frame_len(input logic signed [15:0] adj);
    int l;
    l = PERIOD + int'(adj);
    if (l < MIN_LEN) begin
      l = MIN_LEN;
    end
    frame_len = 16'(l);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  spa_pkg::spa_state_e  state_ff, nxt_state;
  spa_pkg::spa_act_e    act_ff, nxt_act;
  spa_pkg::spa_dac_s    dac_ff, nxt_dac;
  spa_pkg::spa_sel_s    sel;
  logic [15:0]          cnt_ff, nxt_cnt, len_ff, nxt_len;
  logic [3:0]           bit_ff, nxt_bit;
  logic [WW-1:0]        sin_ff, nxt_sin, sout_ff, nxt_sout;
  logic [WW-1:0]        secw_ff, nxt_secw, word;
  logic signed [15:0]   adj_ff, nxt_adj, step_ext;
  logic                 sync_ff, nxt_sync, dout_ff, nxt_dout;
  logic                 req_ff, nxt_req, pend_ff, nxt_pend;
  logic                 secv_ff, nxt_secv;
  logic                 wrap, last_bit, pri_done, sec_done;
  logic [WW-1:0]        fifo_data;
  logic                 fifo_valid, fifo_pop;

  spa_fifo #(
    .W     (WW),
    .DEPTH (spa_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_data   (adc_data),
    .in_valid  (adc_valid),
    .in_ready  (adc_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    step_ext  = 16'(phase_step);
    wrap      = (cnt_ff == len_ff - 16'h0001);
    last_bit  = (bit_ff == 4'hF);
    pri_done  = (state_ff == spa_pkg::ST_PRI) && last_bit;
    sec_done  = (state_ff == spa_pkg::ST_SEC) && last_bit;
    word      = {sin_ff[WW-2:0], din};
    sel       = '{word[spa_pkg::SEC_TOP_POS], word[spa_pkg::SEC_NXT_POS], phase_pin_high, phase_pin_low};
    fifo_pop  = !sync_ff && (cnt_ff == 16'h0000) && fifo_valid;
    nxt_cnt   = wrap ? 16'h0000 : 16'(cnt_ff + 16'h0001);
    nxt_len   = len_ff;
    nxt_state = state_ff;
    nxt_bit   = bit_ff;
    nxt_sin   = sin_ff;
    nxt_sout  = sout_ff;
    nxt_dout  = dout_ff;
    nxt_dac   = dac_ff;
    nxt_dac.valid = 1'b0;
    nxt_secw  = secw_ff;
    nxt_secv  = 1'b0;
    nxt_req   = req_ff;
    nxt_pend  = pend_ff;
    nxt_adj   = adj_ff;
    nxt_act   = act_ff;
    // RL10 secondary sync timing
    nxt_sync  = !(wrap || (req_ff && cnt_ff == 16'(HALF - 1)));
    if (wrap) begin
      nxt_len = 16'(PERIOD);
    end
    // RL4 RL5 applied at rising sync
    if (cnt_ff == 16'h0001 && pend_ff) begin
      nxt_len  = frame_len(adj_ff);
      nxt_pend = 1'b0;
    end
    unique case (state_ff)
      spa_pkg::ST_IDLE: begin
        if (!sync_ff) begin
          // RL2 exchange starts at falling sync
          nxt_state = (cnt_ff == 16'h0000) ? spa_pkg::ST_PRI : spa_pkg::ST_SEC;
          nxt_bit   = 4'h0;
          // Empty FIFO sends a zero word rather than stalling the frame
          nxt_sout  = (cnt_ff == 16'h0000 && fifo_valid) ? fifo_data : '0;
          nxt_dout  = nxt_sout[WW-1];
          nxt_sout  = {nxt_sout[WW-2:0], 1'b0};
          if (cnt_ff != 16'h0000) begin
            nxt_req = 1'b0;
          end
        end
      end
      spa_pkg::ST_PRI, spa_pkg::ST_SEC: begin
        nxt_sin  = word;
        nxt_dout = sout_ff[WW-1];
        nxt_sout = {sout_ff[WW-2:0], 1'b0};
        nxt_bit  = 4'(bit_ff + 4'h1);
        if (last_bit) begin
          nxt_state = spa_pkg::ST_IDLE;
          nxt_dout  = 1'b0;
        end
        // RL2 DAC bits 15..2 only
        if (pri_done) begin
          nxt_dac = '{word[WW-1:spa_pkg::DAC_LSB], 1'b1};
          nxt_req = (word[spa_pkg::REQ_ONE_POS] && word[spa_pkg::REQ_ZER_POS])
                    || (phase_pin_high && phase_pin_low);
        end
        if (sec_done) begin
          nxt_secw = word;
          nxt_secv = 1'b1;
          // RL1 RL3 RL11 table decode
          nxt_act  = decode(sel);
          // RL6 RL7 RL8 RL9 signed step
          unique case (nxt_act)
            spa_pkg::ACT_DELAY: begin
              nxt_adj  = step_ext;
              nxt_pend = 1'b1;
            end
            spa_pkg::ACT_ADV: begin
              nxt_adj  = 16'(-step_ext);
              nxt_pend = 1'b1;
            end
            default: nxt_pend = 1'b0;
          endcase
        end
      end
      default: nxt_state = spa_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= spa_pkg::ST_IDLE;
      cnt_ff   <= 16'h0000;
      len_ff   <= 16'(PERIOD);
      bit_ff   <= 4'h0;
      sin_ff   <= '0;
      sout_ff  <= '0;
      dout_ff  <= 1'b0;
      sync_ff  <= 1'b1;
      dac_ff   <= '0;
      secw_ff  <= '0;
      secv_ff  <= 1'b0;
      req_ff   <= 1'b0;
      pend_ff  <= 1'b0;
      adj_ff   <= 16'h0000;
      act_ff   <= spa_pkg::ACT_NONE;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      len_ff   <= nxt_len;
      bit_ff   <= nxt_bit;
      sin_ff   <= nxt_sin;
      sout_ff  <= nxt_sout;
      dout_ff  <= nxt_dout;
      sync_ff  <= nxt_sync;
      dac_ff   <= nxt_dac;
      secw_ff  <= nxt_secw;
      secv_ff  <= nxt_secv;
      req_ff   <= nxt_req;
      pend_ff  <= nxt_pend;
      adj_ff   <= nxt_adj;
      act_ff   <= nxt_act;
    end
  end

  assign frame_sync_n = sync_ff;
  assign dout         = dout_ff;
  assign dac_out      = dac_ff;
  assign sec_word     = secw_ff;
  assign sec_valid    = secv_ff;
  assign phase_action = act_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_no_action;
    sec_done && decode(sel) == spa_pkg::ACT_NONE |=> !pend_ff && act_ff == spa_pkg::ACT_NONE;
  endproperty
  a_no_action: assert property (p_no_action) else $error("unlisted decode changed phase"); // RL1

  property p_exchange;
    cnt_ff == 16'h0000 && !sync_ff |-> ##17 dac_ff.valid;
  endproperty
  a_exchange: assert property (p_exchange) else $error("DAC word not taken after sync"); // RL2

  property p_pins_ignored;
    sec_done && word[spa_pkg::SEC_TOP_POS] != word[spa_pkg::SEC_NXT_POS]
      |=> pend_ff && act_ff == ($past(word[spa_pkg::SEC_TOP_POS]) ? spa_pkg::ACT_ADV : spa_pkg::ACT_DELAY);
  endproperty
  a_pins_ignored: assert property (p_pins_ignored) else $error("pins affected decode"); // RL3

  property p_delay_bits;
    sec_done && word[15:14] == 2'b01 |=> pend_ff && adj_ff == $past(step_ext);
  endproperty
  a_delay_bits: assert property (p_delay_bits) else $error("delay step wrong"); // RL4

  property p_adv_bits;
    sec_done && word[15:14] == 2'b10 |=> pend_ff && adj_ff == 16'(-$past(step_ext));
  endproperty
  a_adv_bits: assert property (p_adv_bits) else $error("advance step wrong"); // RL5

  property p_delay_pins;
    sec_done && word[15:14] == 2'b11 && !phase_pin_high && phase_pin_low |=> act_ff == spa_pkg::ACT_DELAY;
  endproperty
  a_delay_pins: assert property (p_delay_pins) else $error("pin delay missed"); // RL6

  property p_adv_pins;
    sec_done && word[15:14] == 2'b11 && phase_pin_high && !phase_pin_low |=> act_ff == spa_pkg::ACT_ADV;
  endproperty
  a_adv_pins: assert property (p_adv_pins) else $error("pin advance missed"); // RL7

  property p_neg_delay;
    cnt_ff == 16'h0001 && pend_ff && act_ff == spa_pkg::ACT_DELAY && adj_ff < 0 |=> len_ff < 16'(PERIOD);
  endproperty
  a_neg_delay: assert property (p_neg_delay) else $error("negative delay not earlier"); // RL8

  property p_neg_adv;
    cnt_ff == 16'h0001 && pend_ff && act_ff == spa_pkg::ACT_ADV && adj_ff > 0 |=> len_ff > 16'(PERIOD);
  endproperty
  a_neg_adv: assert property (p_neg_adv) else $error("negative advance not later"); // RL9

  property p_sec_sync;
    req_ff && cnt_ff == 16'(HALF - 1) |=> !sync_ff && cnt_ff == 16'(HALF) ##1 state_ff == spa_pkg::ST_SEC;
  endproperty
  a_sec_sync: assert property (p_sec_sync) else $error("secondary sync misplaced"); // RL10

  property p_equal_pins;
    sec_done && word[15:14] == 2'b11 && phase_pin_high == phase_pin_low |=> !pend_ff;
  endproperty
  a_equal_pins: assert property (p_equal_pins) else $error("equal pins moved phase"); // RL11

  c_delay: cover property (sec_done && decode(sel) == spa_pkg::ACT_DELAY);
  c_adv:   cover property (sec_done && decode(sel) == spa_pkg::ACT_ADV);
  c_apply: cover property (cnt_ff == 16'h0001 && pend_ff);

endmodule

`default_nettype wire

// file: verification/spa_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Host serial port, one word per frame sync
// ----------------------------------------------------------------
module spa_host_model (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        frame_sync_n,
  input  wire logic        dout,
  output logic             din,
  input  wire logic        req,
  input  wire logic        pins_req,
  input  wire logic [15:0] sec_data,
  output logic [15:0]      rx_word,
  output logic             rx_done,
  output logic             rx_sec,
  output logic [15:0]      last_pri
);
  logic [15:0] tx;
  logic [4:0]  cnt;
  logic [7:0]  seq;
  logic        pend;
  logic        sec_next;
  logic        sent;

  always @(posedge ref_clk) begin
    rx_done <= 1'h0;
    if (sys_rst) begin
      din <= 1'h1;
      cnt <= 5'h00;
      seq <= 8'h00;
      pend <= 1'h0;
      sec_next <= 1'h0;
      sent <= 1'h0;
      rx_sec <= 1'h0;
    end else begin
      if (frame_sync_n == 1'h0) begin
        rx_sec <= sec_next;
        if (sec_next) begin
          tx = sec_data;
        end else begin
          // Request bits ask for one secondary word
          tx = {seq, 6'h29, {2{pend}}};
          seq <= seq + 8'h01;
          last_pri <= tx;
          sent <= pend;
          pend <= 1'h0;
        end
        sec_next <= 1'h0;
        din <= tx[15];
        cnt <= 5'h10;
      end else if (cnt != 5'h00) begin
        rx_word <= {rx_word[14:0], dout};
        cnt <= cnt - 5'h01;
        din <= (cnt > 5'h01) ? tx[cnt-5'h02] : ~din;
        rx_done <= (cnt == 5'h01);
        // Mirrors the device: request bits or both pins at word end
        if (cnt == 5'h01 && !rx_sec)
          sec_next <= sent || pins_req;
      end else begin
        // Released line toggles, never a stale bit
        din <= ~din;
      end
      if (req)
        pend <= 1'h1;
    end
  end
endmodule

`default_nettype wire

// file: verification/test_sample_phase_adjust_control.sv
`timescale 1ns/100ps
`default_nettype none

module test_sample_phase_adjust_control;
  localparam int P = 64;

  typedef struct packed {
    logic [1:0]         top;
    logic               hi;
    logic               lo;
    logic [7:0]         step;
    spa_pkg::spa_act_e  act;
  } spa_row_s;

  logic               ref_clk, sys_rst, din, hi, lo, adc_valid, adc_ready;
  logic               sync_n, dout, sec_valid, req, rx_done, rx_sec;
  logic signed [7:0]  step;
  logic [15:0]        adc_data, sec_word, sec_data, rx_word, last_pri;
  spa_pkg::spa_dac_s  dac;
  spa_pkg::spa_act_e  phase_action;
  int                 mismatches, checks, gap, last_gap, n;
  logic [15:0]        q[$];

  spa_row_s rows [11] = '{
    '{2'h0, 1'h0, 1'h1, 8'h05, spa_pkg::ACT_NONE},
    '{2'h1, 1'h0, 1'h0, 8'h05, spa_pkg::ACT_DELAY},
    '{2'h2, 1'h0, 1'h0, 8'h05, spa_pkg::ACT_ADV},
    '{2'h3, 1'h0, 1'h0, 8'h05, spa_pkg::ACT_NONE},
    '{2'h3, 1'h0, 1'h1, 8'h05, spa_pkg::ACT_DELAY},
    '{2'h3, 1'h1, 1'h0, 8'h05, spa_pkg::ACT_ADV},
    '{2'h1, 1'h0, 1'h0, 8'hFB, spa_pkg::ACT_DELAY},
    '{2'h2, 1'h0, 1'h0, 8'hFB, spa_pkg::ACT_ADV},
    '{2'h1, 1'h1, 1'h0, 8'h05, spa_pkg::ACT_DELAY},
    '{2'h2, 1'h0, 1'h1, 8'h05, spa_pkg::ACT_ADV},
    '{2'h3, 1'h1, 1'h1, 8'h05, spa_pkg::ACT_NONE}
  };

  spa_phase_ctrl #(.PERIOD(P)) u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .din(din), .phase_pin_high(hi), .phase_pin_low(lo),
    .phase_step(step), .adc_data(adc_data), .adc_valid(adc_valid), .adc_ready(adc_ready),
    .frame_sync_n(sync_n), .dout(dout), .dac_out(dac), .sec_word(sec_word), .sec_valid(sec_valid),
    .phase_action(phase_action)
  );

  spa_host_model u_host (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .frame_sync_n(sync_n), .dout(dout), .din(din), .req(req),
    .pins_req(hi && lo),
    .sec_data(sec_data), .rx_word(rx_word), .rx_done(rx_done), .rx_sec(rx_sec), .last_pri(last_pri)
  );

  // ----------------------------------------------------------------
  // Report
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_val(string nm, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_act(string nm, spa_pkg::spa_act_e e, spa_pkg::spa_act_e g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // Bounded wait, a hang ends the run
  task automatic tick(inout int k);
    @(posedge ref_clk);
    k++;
    if (k > 600) begin
      mismatches++;
      $display("MISMATCH wait expected event seen timeout");
      test_done();
    end
  endtask

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (sync_n === 1'h0) begin
      last_gap <= gap;
      gap <= 1;
    end else begin
      gap <= gap + 1;
    end
    if (adc_valid && adc_ready)
      q.push_back(adc_data);
    if (rx_done && rx_sec)
      chk_val("secondary reply", 16'h0000, rx_word);
    if (rx_done && !rx_sec)
      chk_val("adc word", (q.size() > 0) ? q.pop_front() : 16'h0000, rx_word);
    if (dac.valid === 1'h1)
      chk_val("dac data", {2'h0, last_pri[15:2]}, {2'h0, dac.data});
  end

  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'h1;
    hi = 1'h0;
    lo = 1'h0;
    step = 8'h00;
    adc_data = 16'hC350;
    adc_valid = 1'h0;
    req = 1'h0;
    sec_data = 16'h0000;
    repeat (2) @(posedge ref_clk);
    chk_val("reset sync", 16'h0001, {15'h0, sync_n});
    chk_val("reset dout", 16'h0000, {15'h0, dout});
    chk_val("reset ready", 16'h0000, {15'h0, adc_ready});
    sys_rst <= 1'h0;
    $display("test reset done");
    // Fill past depth, the last offers are refused
    adc_valid <= 1'h1;
    repeat (24) begin
      @(posedge ref_clk);
      if (adc_ready)
        adc_data <= adc_data + 16'h0101;
    end
    adc_valid <= 1'h0;
    chk_val("fifo level", 16'h0010, 16'(q.size()));
    chk_val("fifo full", 16'h0000, {15'h0, adc_ready});
    $display("test fifo fill done");
    foreach (rows[i]) begin
      @(posedge ref_clk);
      hi <= rows[i].hi;
      lo <= rows[i].lo;
      step <= rows[i].step;
      sec_data <= {rows[i].top, 14'h1A5C};
      // Both pins high request the secondary word by themselves
      req <= !(rows[i].hi && rows[i].lo);
      @(posedge ref_clk);
      req <= 1'h0;
      n = 0;
      while (sec_valid !== 1'h1)
        tick(n);
      chk_val("secondary word", {rows[i].top, 14'h1A5C}, sec_word);
      chk_act("action", rows[i].act, phase_action);
      chk_val("secondary sync gap", 16'(P / 2), 16'(last_gap));
      // Pins low again so the next primary asks for nothing
      hi <= 1'h0;
      lo <= 1'h0;
      while (sync_n !== 1'h0)
        tick(n);
      tick(n);
      while (sync_n !== 1'h0)
        tick(n);
      #1;
      chk_val("frame length", 16'(P + ((rows[i].act == spa_pkg::ACT_DELAY) ? $signed(rows[i].step) :
        (rows[i].act == spa_pkg::ACT_ADV) ? -$signed(rows[i].step) : 0)), 16'(last_gap));
      $display("test row %0d done", i);
    end
    // Reset in mid-run clears the phase state
    @(posedge ref_clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    chk_val("mid reset sync", 16'h0001, {15'h0, sync_n});
    chk_val("mid reset dout", 16'h0000, {15'h0, dout});
    chk_val("mid reset valid", 16'h0000, {15'h0, sec_valid});
    chk_act("mid reset action", spa_pkg::ACT_NONE, phase_action);
    sys_rst <= 1'h0;
    q.delete();
    n = 0;
    while (sync_n !== 1'h0)
      tick(n);
    // Seen at the edge that ends the first low cycle
    chk_val("sync after reset", 16'(P + 1), 16'(n));
    $display("test mid reset done");
    test_done();
  end
endmodule

`default_nettype wire
